// ===== verilog/osc_pkg.sv
// What this block does
// - Security bit 0 blocks JTAG tile access.
// - Security bit 1 refuses other-tile link access.
// - Security bit 5 forces boot from OTP 0.
// - Security bit 7 enables redundant OTP rows.
// - Bits 8-11 lock programming of sectors 0-3.
// - Bit 12 refuses all OTP programming.
// - Bit 13 denies JTAG read/write of OTP.
// - Bit 14 disables the debug sync pin.
// - Bits 21-15 are readable general-purpose field.
// - Bits 31-22 extend the JTAG user code.
// - OTP is four sectors of 512 32-bit rows.
// - Security word loads from OTP before use.
// - Remaining OTP is copied to SRAM first.
// - Address port is 16-bit, ID 0x100200.
// - Data port is 32-bit, ID 0x200100.
// - Control port is 16-bit, ID 0x100300.
// - User-code read returns bits 31-22, zero if blank.
// - Each tile owns its OTP and security logic.
`default_nettype none
package osc_pkg;
	// Security word layout
	localparam int SEC_W = 32;
	localparam int BIT_JTAG_DIS = 0;
	localparam int BIT_LINK_DIS = 1;
	localparam int BIT_SEC_BOOT = 5;
	localparam int BIT_REDUN_EN = 7;
	localparam int BIT_LOCK_LO = 8;
	localparam int BIT_MASTER_LOCK = 12;
	localparam int BIT_JTAG_OTP_DIS = 13;
	localparam int BIT_DBG_DIS = 14;
	localparam int GP_LO = 15;
	localparam int GP_HI = 21;
	localparam int GP_W = GP_HI - GP_LO + 1;
	localparam int UID_LO = 22;
	localparam int UID_HI = 31;
	localparam int UID_W = UID_HI - UID_LO + 1;
	localparam logic [SEC_W-1:0] SEC_RESET = 32'h00000000;
	// OTP array geometry
	localparam int SECTORS = 4;
	localparam int SECT_AW = 2;
	localparam int ROWS_PER_SECT = 512;
	localparam int ROW_AW = 9;
	localparam int ROW_W = 32;
	localparam int OTP_ROWS = SECTORS * ROWS_PER_SECT;
	localparam int OTP_AW = SECT_AW + ROW_AW;
	localparam logic [OTP_AW-1:0] OTP_LAST = 11'h7FF;
	localparam logic [OTP_AW-1:0] BOOT_ADDR = 11'h000;
	localparam int REDUN_ROWS = 16;
	localparam int REDUN_AW = 4;
	localparam int REDUN_SEL_BIT = 11;
	localparam logic [ROW_W-1:0] ROW_BLANK = 32'h00000000;
	// Processor I/O ports
	localparam int RES_ID_W = 24;
	localparam int ADDR_PORT_W = 16;
	localparam int DATA_PORT_W = 32;
	localparam int CTRL_PORT_W = 16;
	localparam logic [RES_ID_W-1:0] ID_ADDR_PORT = 24'h100200;
	localparam logic [RES_ID_W-1:0] ID_DATA_PORT = 24'h200100;
	localparam logic [RES_ID_W-1:0] ID_CTRL_PORT = 24'h100300;
	localparam int CTRL_PROG_ROW = 0;
	localparam int CTRL_PROG_SEC = 1;
	localparam int CTRL_READ_ROW = 2;
	// Power-up sequence
	typedef enum logic [1:0] {
		ST_LOAD,
		ST_COPY,
		ST_RUN
	} osc_state_t;
endpackage
`default_nettype wire

// ===== verilog/osc_otp_security_control.sv
`timescale 1ns/10ps
`default_nettype none
module osc_otp_security_control (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	// Processor I/O port writes
	input wire logic io_wr_in,
	input wire logic [osc_pkg::RES_ID_W-1:0] io_res_id_in,
	input wire logic [osc_pkg::DATA_PORT_W-1:0] io_wdata_in,
	output logic prog_done_out,
	output logic prog_refused_out,
	output logic [osc_pkg::ROW_W-1:0] rd_data_out,
	// JTAG access to OTP
	input wire logic jtag_otp_req_in,
	input wire logic jtag_otp_we_in,
	input wire logic [osc_pkg::ADDR_PORT_W-1:0] jtag_otp_addr_in,
	input wire logic [osc_pkg::ROW_W-1:0] jtag_otp_wdata_in,
	output logic jtag_otp_ready_out,
	output logic jtag_otp_ack_out,
	output logic jtag_otp_denied_out,
	output logic [osc_pkg::ROW_W-1:0] jtag_otp_rdata_out,
	// JTAG tile-state, link and debug gating
	input wire logic jtag_state_req_in,
	output logic jtag_state_grant_out,
	input wire logic link_req_in,
	output logic link_grant_out,
	output logic link_refused_out,
	input wire logic dbg_break_in,
	input wire logic debug_n_in,
	output logic debug_n_out,
	output logic debug_n_oe_out,
	output logic dbg_request_out,
	// Boot copy to SRAM
	output logic copy_valid_out,
	input wire logic copy_ready_in,
	output logic [osc_pkg::OTP_AW-1:0] copy_addr_out,
	output logic [osc_pkg::ROW_W-1:0] copy_data_out,
	output logic boot_go_out,
	output logic boot_from_otp_out,
	output logic [osc_pkg::OTP_AW-1:0] boot_addr_out,
	// Security word views
	output logic redun_en_out,
	output logic [osc_pkg::SEC_W-1:0] tile_security_word_out,
	output logic [osc_pkg::GP_W-1:0] gp_field_out,
	output logic [osc_pkg::UID_W-1:0] user_ident_extension_out
);
	import osc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Storage
	// OTP cells are not cleared by reset: reset models power-up of the
	// logic only, the fuses keep what was burned.
	logic [ROW_W-1:0] otp_mem [OTP_ROWS]; // Main array
	logic [ROW_W-1:0] redun_mem [REDUN_ROWS]; // Spare rows
	logic [SEC_W-1:0] sec_store; // Burned security word
	// Blank fuses read as zero
	initial begin
		for (int i = 0; i < OTP_ROWS; i++) begin
			otp_mem[i] = ROW_BLANK;
		end
		for (int j = 0; j < REDUN_ROWS; j++) begin
			redun_mem[j] = ROW_BLANK;
		end
		sec_store = SEC_RESET;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	osc_state_t state_ff, nxt_state; // Power-up sequence state
	logic [SEC_W-1:0] tile_security_word_ff; // Loaded once per power-up
	logic [ADDR_PORT_W-1:0] prog_addr_ff; // Address port
	logic [DATA_PORT_W-1:0] prog_data_ff; // Data port
	logic [OTP_AW-1:0] copy_idx_ff; // Copy pointer
	logic [ROW_W-1:0] copy_data_ff; // Row being offered
	logic prog_done_ff; // Completion pulse
	logic prog_refused_ff; // Refusal pulse
	logic [ROW_W-1:0] rd_data_ff; // Processor read data
	logic jtag_ack_ff; // JTAG completion pulse
	logic jtag_denied_ff; // JTAG refusal pulse
	logic [ROW_W-1:0] jtag_rdata_ff; // JTAG read data

	////////////////////////////////////////////////////////////////////////
	// Security bit decode
	wire running = (state_ff == ST_RUN); // Features live only now
	wire [SEC_W-1:0] sw = tile_security_word_ff;
	wire jtag_dis = sw[BIT_JTAG_DIS];
	wire link_dis = sw[BIT_LINK_DIS];
	wire redun_en = sw[BIT_REDUN_EN];
	wire master_lock = sw[BIT_MASTER_LOCK];
	wire jtag_otp_dis = sw[BIT_JTAG_OTP_DIS];
	wire dbg_dis = sw[BIT_DBG_DIS];
	wire [SECTORS-1:0] sect_lock = sw[BIT_LOCK_LO +: SECTORS];

	////////////////////////////////////////////////////////////////////////
	// Processor port decode
	// address port select
	wire sel_addr = io_wr_in && (io_res_id_in == ID_ADDR_PORT);
	wire sel_data = io_wr_in && (io_res_id_in == ID_DATA_PORT);
	wire sel_ctrl = io_wr_in && (io_res_id_in == ID_CTRL_PORT);
	wire [CTRL_PORT_W-1:0] ctrl_word = io_wdata_in[CTRL_PORT_W-1:0];
	wire cmd_prog = sel_ctrl && ctrl_word[CTRL_PROG_ROW];
	wire cmd_sec = sel_ctrl && ctrl_word[CTRL_PROG_SEC] && !cmd_prog;
	wire cmd_read = sel_ctrl && ctrl_word[CTRL_READ_ROW] && !cmd_prog
		&& !cmd_sec;
	wire proc_op = cmd_prog || cmd_sec || cmd_read;

	// Address split shared by both requesters
	wire p_redun = prog_addr_ff[REDUN_SEL_BIT];
	wire [OTP_AW-1:0] p_row = prog_addr_ff[OTP_AW-1:0];
	wire [SECT_AW-1:0] p_sect = p_row[OTP_AW-1 -: SECT_AW];
	wire [REDUN_AW-1:0] p_ridx = prog_addr_ff[REDUN_AW-1:0];
	wire j_redun = jtag_otp_addr_in[REDUN_SEL_BIT];
	wire [OTP_AW-1:0] j_row = jtag_otp_addr_in[OTP_AW-1:0];
	wire [SECT_AW-1:0] j_sect = j_row[OTP_AW-1 -: SECT_AW];
	wire [REDUN_AW-1:0] j_ridx = jtag_otp_addr_in[REDUN_AW-1:0];

	// Read paths; a spare row reads blank while spares are off
	// spare rows gated
	wire [ROW_W-1:0] p_rd = p_redun ? (redun_en ? redun_mem[p_ridx] :
		ROW_BLANK) : otp_mem[p_row];
	wire [ROW_W-1:0] j_rd = j_redun ? (redun_en ? redun_mem[j_ridx] :
		ROW_BLANK) : otp_mem[j_row];

	// Refusal terms for the processor
	// sector locks
	wire p_sect_locked = !p_redun && sect_lock[p_sect];
	wire p_row_refuse = !running || master_lock || p_sect_locked
		|| (p_redun && !redun_en);
	wire p_sec_refuse = !running || master_lock;
	wire p_refuse = (cmd_prog && p_row_refuse) ||
		(cmd_sec && p_sec_refuse) || (cmd_read && !running);
	wire p_burn_row = cmd_prog && !p_row_refuse;
	wire p_burn_sec = cmd_sec && !p_sec_refuse;

	// JTAG access; processor has priority, JTAG waits on ready
	wire j_take = jtag_otp_req_in && !proc_op;
	// JTAG disable also closes memory contents
	wire j_gate = !running || jtag_dis || jtag_otp_dis;
	wire j_wr_refuse = j_gate || master_lock || (j_redun && !redun_en)
		|| (!j_redun && sect_lock[j_sect]);
	wire j_refuse = jtag_otp_we_in ? j_wr_refuse : j_gate;
	wire j_burn = j_take && jtag_otp_we_in && !j_wr_refuse;

	////////////////////////////////////////////////////////////////////////
	// Power-up sequence
	// load first, then copy, then run
	wire copy_accept = (state_ff == ST_COPY) && copy_ready_in;
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_LOAD: begin
				nxt_state = ST_COPY;
			end
			ST_COPY: begin
				// every row goes out before boot
				if (copy_accept && copy_idx_ff == OTP_LAST) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				nxt_state = ST_RUN;
			end
			default: begin
				nxt_state = ST_LOAD;
			end
		endcase
	end

	// State and security word
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_ff <= ST_LOAD;
			tile_security_word_ff <= SEC_RESET;
		end else if (clk_en_in) begin
			state_ff <= nxt_state;
			// captured only in the load state
			if (state_ff == ST_LOAD) begin
				tile_security_word_ff <= sec_store;
			end
		end
	end

	// Copy pointer and staged row
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			copy_idx_ff <= BOOT_ADDR;
			copy_data_ff <= ROW_BLANK;
		end else if (clk_en_in) begin
			if (state_ff == ST_LOAD) begin
				copy_idx_ff <= BOOT_ADDR;
				copy_data_ff <= otp_mem[BOOT_ADDR];
			end else if (copy_accept && copy_idx_ff != OTP_LAST) begin
				copy_idx_ff <= copy_idx_ff + 11'h001;
				copy_data_ff <= otp_mem[copy_idx_ff + 11'h001];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port latches and result pulses
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prog_addr_ff <= 16'h0000;
			prog_data_ff <= 32'h00000000;
			prog_done_ff <= 1'b0;
			prog_refused_ff <= 1'b0;
			rd_data_ff <= ROW_BLANK;
		end else if (clk_en_in) begin
			if (sel_addr) begin
				prog_addr_ff <= io_wdata_in[ADDR_PORT_W-1:0];
			end
			if (sel_data) begin
				prog_data_ff <= io_wdata_in;
			end
			prog_done_ff <= proc_op && !p_refuse;
			prog_refused_ff <= p_refuse;
			if (cmd_read && running) begin
				rd_data_ff <= p_rd;
			end
		end
	end

	// JTAG result registers
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			jtag_ack_ff <= 1'b0;
			jtag_denied_ff <= 1'b0;
			jtag_rdata_ff <= ROW_BLANK;
		end else if (clk_en_in) begin
			jtag_ack_ff <= j_take && !j_refuse;
			jtag_denied_ff <= j_take && j_refuse;
			if (j_take && !jtag_otp_we_in && !j_gate) begin
				jtag_rdata_ff <= j_rd;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fuse burning: bits can only go from 0 to 1
	// four sectors of 512 rows of 32 bits
	// Plain always on purpose: the blank-fuse initial block also writes
	// these cells, which a strict always_ff would not allow
	always @(posedge clk_sys_in) begin
		if (clk_en_in) begin
			if (p_burn_row && !p_redun) begin
				otp_mem[p_row] <= otp_mem[p_row] | prog_data_ff;
			end else if (j_burn && !j_redun) begin
				otp_mem[j_row] <= otp_mem[j_row] | jtag_otp_wdata_in;
			end
			if (p_burn_row && p_redun) begin
				redun_mem[p_ridx] <= redun_mem[p_ridx] | prog_data_ff;
			end else if (j_burn && j_redun) begin
				redun_mem[j_ridx] <= redun_mem[j_ridx] | jtag_otp_wdata_in;
			end
			// New word takes effect only after the next power-up
			if (p_burn_sec) begin
				sec_store <= sec_store | prog_data_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign prog_done_out = prog_done_ff;
	assign prog_refused_out = prog_refused_ff;
	assign rd_data_out = rd_data_ff;
	assign jtag_otp_ready_out = !proc_op;
	assign jtag_otp_ack_out = jtag_ack_ff;
	assign jtag_otp_denied_out = jtag_denied_ff;
	assign jtag_otp_rdata_out = jtag_rdata_ff;
	assign jtag_state_grant_out = jtag_state_req_in && running && !jtag_dis;
	assign link_grant_out = link_req_in && running && !link_dis;
	assign link_refused_out = link_req_in && !(running && !link_dis);
	assign debug_n_out = 1'b0;
	assign debug_n_oe_out = dbg_break_in && running && !dbg_dis;
	assign dbg_request_out = !debug_n_in && running && !dbg_dis;
	assign copy_valid_out = (state_ff == ST_COPY);
	assign copy_addr_out = copy_idx_ff;
	assign copy_data_out = copy_data_ff;
	assign boot_go_out = running;
	assign boot_from_otp_out = sw[BIT_SEC_BOOT];
	assign boot_addr_out = BOOT_ADDR;
	assign redun_en_out = redun_en;
	assign tile_security_word_out = sw;
	assign gp_field_out = sw[GP_HI:GP_LO];
	assign user_ident_extension_out = sw[UID_HI:UID_LO];
endmodule
`default_nettype wire

// ===== tb/osc_properties.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Port-level watch on the security and OTP control block
module osc_properties
	import osc_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic io_wr_in,
	input wire logic [23:0] io_res_id_in,
	input wire logic [31:0] io_wdata_in,
	input wire logic prog_done_out,
	input wire logic prog_refused_out,
	input wire logic jtag_otp_req_in,
	input wire logic jtag_otp_ready_out,
	input wire logic jtag_otp_ack_out,
	input wire logic jtag_otp_denied_out,
	input wire logic jtag_state_grant_out,
	input wire logic link_grant_out,
	input wire logic dbg_break_in,
	input wire logic debug_n_oe_out,
	input wire logic copy_valid_out,
	input wire logic copy_ready_in,
	input wire logic [10:0] copy_addr_out,
	input wire logic boot_go_out,
	input wire logic boot_from_otp_out,
	input wire logic redun_en_out,
	input wire logic [31:0] tile_security_word_out,
	input wire logic [6:0] gp_field_out,
	input wire logic [9:0] user_ident_extension_out
);
	// Short alias for the loaded word
	wire logic [31:0] w = tile_security_word_out;
	// Last value on the address port; the lock depends on it
	logic [15:0] addr_ff;
	wire logic addr_wr = clk_en_in && io_wr_in
		&& io_res_id_in == ID_ADDR_PORT;
	// Capture address writes
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			addr_ff <= 16'h0000;
		end else if (addr_wr) begin
			addr_ff <= io_wdata_in[15:0];
		end
	end
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!reset_n_in);
	// Control write as the block takes it
	sequence s_ctrl_wr;
		clk_en_in && io_wr_in && io_res_id_in == ID_CTRL_PORT;
	endsequence
	// JTAG access as the block takes it
	sequence s_jtag_take;
		clk_en_in && jtag_otp_req_in && jtag_otp_ready_out;
	endsequence
	a_jtag_state_gate: assert property (jtag_state_grant_out |-> !w[0])
		else $error("tile state granted while blocked");
	a_link_gate: assert property (link_grant_out |-> !w[1])
		else $error("link granted while blocked");
	a_boot_source: assert property (boot_go_out
		|-> boot_from_otp_out == w[5])
		else $error("boot source differs from word");
	a_redun_follow: assert property (redun_en_out == w[7])
		else $error("spare row enable differs from word");
	a_sector_lock: assert property (s_ctrl_wr
		##0 (io_wdata_in[0] && !addr_ff[11]
		&& w[BIT_LOCK_LO + addr_ff[10:9]])
		|=> prog_refused_out && !prog_done_out && $stable(w))
		else $error("locked sector burn not refused");
	a_master_lock: assert property (s_ctrl_wr ##0 (w[12]
		&& io_wdata_in[1:0] != 2'h0)
		|=> prog_refused_out && !prog_done_out)
		else $error("burn under master lock not refused");
	a_jtag_deny: assert property (s_jtag_take ##0 (w[0] || w[13])
		|=> jtag_otp_denied_out && !jtag_otp_ack_out)
		else $error("JTAG OTP access not denied");
	a_jtag_wait: assert property (s_ctrl_wr
		##0 (io_wdata_in[2:0] != 3'h0) |-> !jtag_otp_ready_out)
		else $error("JTAG ready during processor command");
	a_debug_gate: assert property (debug_n_oe_out
		|-> dbg_break_in && !w[14])
		else $error("debug pin driven while disabled");
	a_user_fields: assert property (gp_field_out == w[21:15]
		&& user_ident_extension_out == w[31:22])
		else $error("user fields differ from word");
	a_copy_end: assert property (clk_en_in && copy_valid_out
		&& copy_ready_in && copy_addr_out == OTP_LAST
		|=> boot_go_out && !copy_valid_out)
		else $error("boot did not follow last row");
	a_gates_shut: assert property (!boot_go_out
		|-> !jtag_state_grant_out && !link_grant_out && !debug_n_oe_out)
		else $error("access granted before boot");
	a_word_hold: assert property (boot_go_out && $past(boot_go_out)
		|-> $stable(w))
		else $error("loaded word changed while running");
endmodule
bind osc_otp_security_control osc_properties i_osc_properties (
	.clk_sys_in, .reset_n_in, .clk_en_in, .io_wr_in, .io_res_id_in,
	.io_wdata_in, .prog_done_out, .prog_refused_out, .jtag_otp_req_in,
	.jtag_otp_ready_out, .jtag_otp_ack_out, .jtag_otp_denied_out,
	.jtag_state_grant_out, .link_grant_out, .dbg_break_in, .debug_n_oe_out,
	.copy_valid_out, .copy_ready_in, .copy_addr_out, .boot_go_out,
	.boot_from_otp_out, .redun_en_out, .tile_security_word_out,
	.gp_field_out, .user_ident_extension_out
);
`default_nettype wire

// ===== tb/osc_sram_sink.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// SRAM side of the boot copy; stalls one cycle in four
module osc_sram_sink (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic copy_valid_in,
	input wire logic [10:0] copy_addr_in,
	input wire logic [31:0] copy_data_in,
	output logic copy_ready_out,
	output logic [11:0] rows_out,
	output logic order_bad_out,
	output logic [31:0] row5_out
);
	logic [1:0] tick_ff;
	assign copy_ready_out = tick_ff != 2'h3;
	// Count rows, check order, keep row 5
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tick_ff <= 2'h0;
			rows_out <= 12'h000;
			order_bad_out <= 1'b0;
			row5_out <= 32'h00000000;
		end else begin
			tick_ff <= tick_ff + 2'h1;
			if (copy_valid_in && copy_ready_out) begin
				rows_out <= rows_out + 12'h001;
				order_bad_out <= order_bad_out
					|| copy_addr_in != rows_out[10:0];
				if (copy_addr_in == 11'h005) begin
					row5_out <= copy_data_in;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/osc_otp_security_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module osc_otp_security_control_tb_top;
	import osc_pkg::*;
	typedef struct packed {logic [15:0] a; logic [31:0] d; logic [15:0] c;
		logic ok; logic [31:0] rd;} osc_row_t;
	logic clk_sys_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic clk_en_in = 1'b1;
	logic io_wr_in = 1'b0;
	logic [23:0] io_res_id_in = 24'h000000;
	logic [31:0] io_wdata_in = 32'h00000000;
	logic jtag_otp_req_in = 1'b0;
	logic jtag_otp_we_in = 1'b0;
	logic [15:0] jtag_otp_addr_in = 16'h0000;
	logic [31:0] jtag_otp_wdata_in = 32'h00000000;
	logic jtag_state_req_in = 1'b1;
	logic link_req_in = 1'b1;
	logic dbg_break_in = 1'b1;
	logic debug_n_in = 1'b0;
	logic copy_ready_in, prog_done_out, prog_refused_out, jtag_otp_ready_out;
	logic jtag_otp_ack_out, jtag_otp_denied_out, jtag_state_grant_out;
	logic link_grant_out, link_refused_out, debug_n_out, debug_n_oe_out;
	logic dbg_request_out, copy_valid_out, boot_go_out, boot_from_otp_out;
	logic redun_en_out, order_bad;
	logic [31:0] rd_data_out, jtag_otp_rdata_out, copy_data_out, row5;
	logic [31:0] tile_security_word_out;
	logic [10:0] copy_addr_out, boot_addr_out;
	logic [11:0] rows;
	logic [6:0] gp_field_out;
	logic [9:0] user_ident_extension_out;
	int n_fail = 0;
	int total_checks = 0;
	// Plain burns and reads on a blank word
	osc_row_t tbl [7] = '{'{16'h0005, 32'hA5A50F0F, 16'h1, 1'b1, 32'h0},
		'{16'h0005, 32'h0000F0F0, 16'h1, 1'b1, 32'h0},
		'{16'h0005, 32'h0, 16'h4, 1'b1, 32'hA5A5FFFF},
		'{16'h0800, 32'h1, 16'h1, 1'b0, 32'h0},
		'{16'h07FF, 32'h12345678, 16'h1, 1'b1, 32'h0},
		'{16'h07FF, 32'h0, 16'h4, 1'b1, 32'h12345678},
		'{16'h0800, 32'h0, 16'h4, 1'b1, 32'h0}};
	always #50 clk_sys_in = ~clk_sys_in;
	osc_otp_security_control i_osc_otp_security_control (.clk_sys_in,
		.reset_n_in, .clk_en_in, .io_wr_in, .io_res_id_in, .io_wdata_in,
		.prog_done_out, .prog_refused_out, .rd_data_out, .jtag_otp_req_in,
		.jtag_otp_we_in, .jtag_otp_addr_in, .jtag_otp_wdata_in,
		.jtag_otp_ready_out, .jtag_otp_ack_out, .jtag_otp_denied_out,
		.jtag_otp_rdata_out, .jtag_state_req_in, .jtag_state_grant_out,
		.link_req_in, .link_grant_out, .link_refused_out, .dbg_break_in,
		.debug_n_in, .debug_n_out, .debug_n_oe_out, .dbg_request_out,
		.copy_valid_out, .copy_ready_in, .copy_addr_out, .copy_data_out,
		.boot_go_out, .boot_from_otp_out, .boot_addr_out, .redun_en_out,
		.tile_security_word_out, .gp_field_out, .user_ident_extension_out);
	osc_sram_sink i_osc_sram_sink (.clk_sys_in, .reset_n_in,
		.copy_valid_in(copy_valid_out), .copy_addr_in(copy_addr_out),
		.copy_data_in(copy_data_out), .copy_ready_out(copy_ready_in),
		.rows_out(rows), .order_bad_out(order_bad), .row5_out(row5));
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	task automatic wr(input logic [23:0] id, input logic [31:0] d);
		@(posedge clk_sys_in);
		io_wr_in <= 1'b1;
		io_res_id_in <= id;
		io_wdata_in <= d;
	endtask
	// Address, data, control back to back; answer one cycle on
	task automatic prog(input logic [15:0] a, input logic [31:0] d,
		input logic [15:0] c, input logic ok);
		wr(ID_ADDR_PORT, {16'h0000, a});
		wr(ID_DATA_PORT, d);
		wr(ID_CTRL_PORT, {16'h0000, c});
		@(posedge clk_sys_in);
		io_wr_in <= 1'b0;
		#1;
		chk("prog_done", 32'(ok), 32'(prog_done_out));
		chk("prog_refused", 32'(!ok), 32'(prog_refused_out));
	endtask
	task automatic jt(input logic we, input logic [15:0] a, input logic ok);
		@(posedge clk_sys_in);
		jtag_otp_req_in <= 1'b1;
		jtag_otp_we_in <= we;
		jtag_otp_addr_in <= a;
		jtag_otp_wdata_in <= 32'h0000FFFF;
		@(posedge clk_sys_in);
		jtag_otp_req_in <= 1'b0;
		#1;
		chk("jtag_ack", 32'(ok), 32'(jtag_otp_ack_out));
	endtask
	task automatic boot();
		int i;
		@(posedge clk_sys_in);
		reset_n_in <= 1'b0;
		repeat (5) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		for (i = 0; i < 4000 && boot_go_out !== 1'b1; i++) begin
			@(posedge clk_sys_in);
		end
		#1;
		// A copy that never ends counts as a mismatch
		chk("boot reached", 32'h1, 32'(boot_go_out));
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		n_fail++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge clk_sys_in);
		#1;
		chk("reset word", 32'h0, tile_security_word_out);
		chk("reset boot", 32'h0, 32'(boot_go_out || copy_valid_out));
		@(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		prog(16'h0005, 32'h0, 16'h4, 1'b0);
		boot();
		chk("rows copied", 32'd2048, 32'(rows));
		chk("copy order", 32'h0, 32'(order_bad));
		foreach (tbl[k]) begin
			prog(tbl[k].a, tbl[k].d, tbl[k].c, tbl[k].ok);
			if (tbl[k].c == 16'h4) chk("rd_data", tbl[k].rd, rd_data_out);
		end
		jt(1'b0, 16'h0005, 1'b1);
		chk("jtag rdata", 32'hA5A5FFFF, jtag_otp_rdata_out);
		chk("open gates", 32'hF, {28'h0, jtag_state_grant_out,
			link_grant_out, debug_n_oe_out, dbg_request_out});
		chk("debug pin low", 32'h0, 32'(debug_n_out));
		prog(16'h0000, 32'hAAEAC1A2, 16'h2, 1'b1);
		chk("word pending", 32'h0, tile_security_word_out);
		boot();
		chk("word loaded", 32'hAAEAC1A2, tile_security_word_out);
		chk("boot from otp", 32'h1,
			32'(boot_from_otp_out && boot_addr_out == 11'h000));
		chk("redundant", 32'h1, 32'(redun_en_out));
		chk("gp field", 32'h55, 32'(gp_field_out));
		chk("user id", 32'h2AB, 32'(user_ident_extension_out));
		chk("gates", 32'h9, {28'h0, jtag_state_grant_out,
			link_grant_out, debug_n_oe_out || dbg_request_out,
			link_refused_out});
		chk("sram row5", 32'hA5A5FFFF, row5);
		prog(16'h0003, 32'h1, 16'h1, 1'b0);
		prog(16'h0003, 32'h0, 16'h4, 1'b1);
		chk("locked row", 32'h0, rd_data_out);
		jt(1'b1, 16'h0004, 1'b0);
		prog(16'h0200, 32'h7, 16'h1, 1'b1);
		prog(16'h0800, 32'hF, 16'h1, 1'b1);
		prog(16'h0800, 32'h0, 16'h4, 1'b1);
		chk("spare row", 32'hF, rd_data_out);
		prog(16'h0000, 32'h00003000, 16'h2, 1'b1);
		chk("word held", 32'hAAEAC1A2, tile_security_word_out);
		boot();
		chk("word locked", 32'hAAEAF1A2, tile_security_word_out);
		prog(16'h0201, 32'h1, 16'h1, 1'b0);
		prog(16'h0000, 32'h1, 16'h2, 1'b0);
		jt(1'b0, 16'h0005, 1'b0);
		chk("jtag denied", 32'h1, 32'(jtag_otp_denied_out));
		chk("word kept", 32'hAAEAF1A2, tile_security_word_out);
		// Clock enable low freezes the JTAG answer
		@(posedge clk_sys_in);
		clk_en_in <= 1'b0;
		jt(1'b0, 16'h0005, 1'b0);
		chk("frozen deny", 32'h0, 32'(jtag_otp_denied_out));
		@(posedge clk_sys_in);
		clk_en_in <= 1'b1;
		report_and_stop();
	end
endmodule
`default_nettype wire
